/* hdl/lprg_core.sv */
`timescale 1ns/10ps
module lprg_core
#(
  parameter int unsigned PRESS_DELAY_MS = lprg_pkg::PRESS_DELAY_MS,
  parameter int unsigned ENTRY_DELAY_MS = lprg_pkg::ENTRY_DELAY_MS,
  parameter int unsigned PULSE_TIME_MS  = lprg_pkg::PULSE_TIME_MS,
  parameter bit          FIXED_PULSE    = 1'b0,
  parameter bit          ACTIVE_HIGH    = 1'b0,
  parameter bit          OPEN_DRAIN     = 1'b1,
  // cycle counts; shorten these in simulation
  parameter int unsigned PRESS_CYCLES   = PRESS_DELAY_MS * (lprg_pkg::CLK_HZ / lprg_pkg::MS_PER_S),
  parameter int unsigned ENTRY_CYCLES   = ENTRY_DELAY_MS * (lprg_pkg::CLK_HZ / lprg_pkg::MS_PER_S),
  parameter int unsigned PULSE_CYCLES   = PULSE_TIME_MS * (lprg_pkg::CLK_HZ / lprg_pkg::MS_PER_S)
)
(
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic push_button_input_n_i,
  input  wire logic overvolt_detect_i,
  output logic      reset_out_o,
  output logic      reset_oe_o,
  output logic      reset_active_o,
  output logic      test_mode_o
);
  localparam logic [lprg_pkg::CNT_W-1:0] PRESS_LAST = lprg_pkg::CNT_W'(PRESS_CYCLES - 1);
  localparam logic [lprg_pkg::CNT_W-1:0] SHORT_LAST =
    lprg_pkg::CNT_W'((PRESS_CYCLES / lprg_pkg::TEST_DIVIDER > 0) ?
                     PRESS_CYCLES / lprg_pkg::TEST_DIVIDER - 1 : 0);
  localparam logic [lprg_pkg::CNT_W-1:0] ENTRY_LAST = lprg_pkg::CNT_W'(ENTRY_CYCLES - 1);
  localparam logic [lprg_pkg::CNT_W-1:0] PULSE_LAST = lprg_pkg::CNT_W'(PULSE_CYCLES - 1);

  lprg_pkg::lprg_inputs_t raw;
  lprg_pkg::lprg_inputs_t syn;
  lprg_pkg::lprg_state_t  state_reg;
  logic [lprg_pkg::CNT_W-1:0] cnt_reg;
  logic                   test_reg;
  logic                   entry_reg;
  logic                   active_reg;
  logic                   cause_reg;
  logic                   trig;
  logic                   delay_done;

  // level that holds a follow-the-input reset: over-voltage for entry, else the button
  function automatic logic cause_level(input logic from_ov, input lprg_pkg::lprg_inputs_t lv);
    cause_level = from_ov ? lv.overvolt : lv.pressed;
  endfunction

  assign raw.pressed  = ~push_button_input_n_i;
  assign raw.overvolt = overvolt_detect_i;

  lprg_sync u_sync
  (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .raw_i      (raw),
    .sync_o     (syn)
  );

  // trigger level: over-voltage while not yet in test mode, else the button
  assign trig = (syn.overvolt && !test_reg) ? 1'b1 : syn.pressed;
  assign delay_done = entry_reg ? (cnt_reg == ENTRY_LAST) :
                      test_reg  ? (cnt_reg == SHORT_LAST) : (cnt_reg == PRESS_LAST);

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      test_reg <= 1'b0;
    end
    else if (entry_reg && state_reg == lprg_pkg::LPRG_COUNT && delay_done)
    begin
      test_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      state_reg <= lprg_pkg::LPRG_IDLE;
      cnt_reg   <= '0;
      entry_reg <= 1'b0;
      cause_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        lprg_pkg::LPRG_IDLE:
        begin
          cnt_reg <= '0;
          if (syn.overvolt && !test_reg)
          begin
            entry_reg <= 1'b1;
            state_reg <= lprg_pkg::LPRG_COUNT;
          end
          else if (syn.pressed)
          begin
            entry_reg <= 1'b0;
            state_reg <= lprg_pkg::LPRG_COUNT;
          end
        end
        lprg_pkg::LPRG_COUNT:
        begin
          if (!trig)
          begin
            state_reg <= lprg_pkg::LPRG_IDLE;
            cnt_reg   <= '0;
          end
          else if (delay_done)
          begin
            cnt_reg   <= '0;
            cause_reg <= entry_reg;
            entry_reg <= 1'b0;
            state_reg <= FIXED_PULSE ? lprg_pkg::LPRG_PULSE : lprg_pkg::LPRG_ASSERT;
          end
          else
          begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        lprg_pkg::LPRG_ASSERT:
        begin
          // follow the level that caused the trigger
          if (!cause_level(cause_reg, syn))
          begin
            state_reg <= lprg_pkg::LPRG_IDLE;
          end
        end
        lprg_pkg::LPRG_PULSE:
        begin
          if (cnt_reg == PULSE_LAST)
          begin
            cnt_reg   <= '0;
            state_reg <= lprg_pkg::LPRG_WAIT_REL;
          end
          else
          begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        lprg_pkg::LPRG_WAIT_REL:
        begin
          if (!syn.pressed && !syn.overvolt)
          begin
            state_reg <= lprg_pkg::LPRG_IDLE;
          end
        end
        default:
        begin
          state_reg <= lprg_pkg::LPRG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      active_reg <= 1'b0;
    end
    else
    begin
      active_reg <= (state_reg == lprg_pkg::LPRG_COUNT && trig && delay_done) ||
                    (state_reg == lprg_pkg::LPRG_ASSERT && cause_level(cause_reg, syn)) ||
                    (state_reg == lprg_pkg::LPRG_PULSE && cnt_reg != PULSE_LAST);
    end
  end

  // polarity and drive style
  always_comb
  begin
    if (OPEN_DRAIN)
    begin
      reset_out_o = ACTIVE_HIGH;
      reset_oe_o  = active_reg;
    end
    else
    begin
      reset_out_o = ACTIVE_HIGH ? active_reg : ~active_reg;
      reset_oe_o  = 1'b1;
    end
  end

  assign reset_active_o = active_reg;
  assign test_mode_o    = test_reg;

  chk_pulse_width: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (FIXED_PULSE && $rose(active_reg)) |-> active_reg [*8])
    else $error("fixed pulse ended early");
  chk_test_sticky: assert property (@(posedge core_clk_i) disable iff (srst_i)
    test_reg |=> test_reg)
    else $error("test mode left without reset");
  chk_release_drop: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (!FIXED_PULSE && state_reg == lprg_pkg::LPRG_ASSERT && !cause_reg && !syn.pressed)
    |=> !active_reg)
    else $error("reset held after release");
  chk_no_early: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (state_reg == lprg_pkg::LPRG_COUNT && !delay_done) |=> !active_reg)
    else $error("reset before delay elapsed");
  chk_short_press: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (state_reg == lprg_pkg::LPRG_COUNT && !trig) |=> state_reg == lprg_pkg::LPRG_IDLE
    && cnt_reg == '0)
    else $error("short press not discarded");
  chk_wait_release: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (state_reg == lprg_pkg::LPRG_WAIT_REL && syn.pressed) |=> !active_reg)
    else $error("pulse restarted while held");
  chk_reset_idle: assert property (@(posedge core_clk_i)
    $fell(srst_i) |-> !active_reg && !test_reg && state_reg == lprg_pkg::LPRG_IDLE)
    else $error("not idle after reset");
  chk_entry_mode: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(test_reg) |-> $past(entry_reg) && $past(syn.overvolt))
    else $error("test mode entered without over-voltage");
  chk_od_drive: assert property (@(posedge core_clk_i) disable iff (srst_i)
    OPEN_DRAIN |-> reset_oe_o == active_reg && reset_out_o == ACTIVE_HIGH)
    else $error("open drain drive wrong");

  // entry count finished while the over-voltage or the button still stands
  sequence s_entry_done;
    state_reg == lprg_pkg::LPRG_COUNT && entry_reg && trig && delay_done;
  endsequence
  // shortened press count finished in test mode
  sequence s_short_done;
    state_reg == lprg_pkg::LPRG_COUNT && test_reg && trig && cnt_reg == SHORT_LAST;
  endsequence

  chk_entry_feedback: assert property (@(posedge core_clk_i) disable iff (srst_i)
    s_entry_done |=> test_reg && active_reg)
    else $error("no feedback after test entry");
  chk_short_delay: assert property (@(posedge core_clk_i) disable iff (srst_i)
    s_short_done |=> active_reg)
    else $error("shortened delay not used");
  chk_entry_follow: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (!FIXED_PULSE && state_reg == lprg_pkg::LPRG_ASSERT && cause_reg && !syn.overvolt)
    |=> !active_reg)
    else $error("reset held after over-voltage ended");
endmodule

/* include/lprg_pkg.sv */
// Behaviour
// - in normal mode, a button reset asserts only after button held continuously for long-press delay, 0.5 s to 10 s
// - short presses give no reset; delay count restarts on next press
// - without fixed pulse, reset follows button release immediately, no minimum width
// - with fixed pulse, reset holds exactly pulse time regardless of button
// - over-voltage detect starts a 42 ms test-entry delay before feedback
// - after test-entry delay, reset for pulse time or while over-voltage persists
// - in test mode each press uses long-press delay divided by 128
// - test mode persists until power-on reset; no input leaves it
// - after power-on, normal mode, reset inactive, counters idle
// - reset polarity and open-drain or push-pull drive are build options
package lprg_pkg;
  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned PRESS_DELAY_MS   = 500;
  localparam int unsigned ENTRY_DELAY_MS   = 42;
  localparam int unsigned PULSE_TIME_MS    = 210;
  localparam int unsigned TEST_DIVIDER     = 128;
  localparam int unsigned MS_PER_S         = 1000;
  localparam int unsigned CNT_W            = 32;

  typedef enum logic [2:0]
  {
    LPRG_IDLE,
    LPRG_COUNT,
    LPRG_ASSERT,
    LPRG_PULSE,
    LPRG_WAIT_REL
  } lprg_state_t;

  typedef struct packed
  {
    logic pressed;
    logic overvolt;
  } lprg_inputs_t;

  typedef struct packed
  {
    logic out;
    logic oe;
  } lprg_pin_t;
endpackage

/* hdl/lprg_sync.sv */
`timescale 1ns/10ps
// two-flop synchroniser for the button and over-voltage levels
module lprg_sync
(
  input  wire logic                  core_clk_i,
  input  wire logic                  srst_i,
  input  wire lprg_pkg::lprg_inputs_t raw_i,
  output lprg_pkg::lprg_inputs_t      sync_o
);
  lprg_pkg::lprg_inputs_t meta_reg;
  lprg_pkg::lprg_inputs_t sync_reg;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= raw_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule

/* dv/lprg_pin_model.sv */
`timescale 1ns/10ps
module lprg_pin_model
(
  input  wire logic out_i,
  input  wire logic oe_i,
  output logic      lvl_o
);
  // processor reset line: a released pin rises to the pull-up
  assign lvl_o = oe_i ? out_i : 1'b1;
endmodule

/* dv/tb_lprg_core.sv */
`timescale 1ns/10ps
module tb_lprg_core;
  localparam int N = 256;
  localparam int ENTRY_N = 20;
  localparam int PULSE_N = 10;
  logic        core_clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        btn_n = 1'b1;
  logic        ov = 1'b0;
  logic [1:0]  out;
  logic [1:0]  oe;
  logic [1:0]  act;
  logic [1:0]  tm;
  logic [1:0]  lvl;
  int          fail_count = 0;
  int          total_checks = 0;
  int unsigned seed = 32'he616;
  int          w = 0;
  int          wlast = 0;
  int          rises = 0;
  int          t;

  lprg_core #(.PRESS_CYCLES(N), .ENTRY_CYCLES(ENTRY_N), .PULSE_CYCLES(PULSE_N)) i_lprg_core
  (.core_clk_i(core_clk_i), .srst_i(srst_i), .push_button_input_n_i(btn_n),
   .overvolt_detect_i(ov), .reset_out_o(out[0]), .reset_oe_o(oe[0]),
   .reset_active_o(act[0]), .test_mode_o(tm[0]));
  lprg_core #(.PRESS_CYCLES(N), .ENTRY_CYCLES(ENTRY_N), .PULSE_CYCLES(PULSE_N),
    .FIXED_PULSE(1'b1), .ACTIVE_HIGH(1'b1), .OPEN_DRAIN(1'b0)) i_lprg_core_fix
  (.core_clk_i(core_clk_i), .srst_i(srst_i), .push_button_input_n_i(btn_n),
   .overvolt_detect_i(ov), .reset_out_o(out[1]), .reset_oe_o(oe[1]),
   .reset_active_o(act[1]), .test_mode_o(tm[1]));
  lprg_pin_model i_lprg_pin_model (.out_i(out[0]), .oe_i(oe[0]), .lvl_o(lvl[0]));
  lprg_pin_model i_lprg_pin_model_fix (.out_i(out[1]), .oe_i(oe[1]), .lvl_o(lvl[1]));

  initial
    forever #10 core_clk_i = ~core_clk_i;

  // width of each fixed pulse and number of pulses
  always @(posedge core_clk_i)
    if (act[1] === 1'b1)
      w <= w + 1;
    else if (w != 0)
    begin
      wlast <= w;
      w <= 0;
      rises <= rises + 1;
    end

  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s exp %0h got %0h", name, exp, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // hold the button h cycles; t is the first cycle with reset seen, 0 if none
  task automatic press(int h, output int t);
    t = 0;
    @(posedge core_clk_i);
    btn_n <= 1'b0;
    for (int i = 1; i <= h; i++)
    begin
      @(posedge core_clk_i);
      if (t == 0 && act[0] === 1'b1)
        t = i;
    end
    btn_n <= 1'b1;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    cyc(12);
    srst_i <= 1'b0;
    cyc(2);
    chk("idle act", 2'b00, act);
    chk("idle tm", 2'b00, tm);
    chk("idle pin", 2'b01, lvl);
    for (int k = 0; k < 6; k++)
    begin
      press(k == 0 ? N - 8 : int'(rnd() % 200) + 1, t);
      chk("short press", 0, t);
      cyc(int'(rnd() % 5) + 1);
    end
    chk("no pulse", 0, rises);
    press(N + 40, t);
    chk("press delay", 1, t >= N + 2 && t <= N + 6);
    chk("held pin", 2'b00, lvl);
    chk("held oe", 2'b11, oe);
    cyc(5);
    chk("release act", 0, act[0]);
    chk("release pin", 2'b01, lvl);
    chk("pulse width", 10, wlast);
    chk("one pulse", 1, rises);
    @(posedge core_clk_i);
    ov <= 1'b1;
    cyc(10);
    chk("entry early", 0, act[0]);
    cyc(25);
    chk("entry act", 1, act[0]);
    chk("entry tm", 2'b11, tm);
    ov <= 1'b0;
    cyc(6);
    chk("entry end", 0, act[0]);
    chk("entry width", 10, wlast);
    press(12, t);
    chk("test delay", 1, t >= 2 && t <= 8);
    cyc(20);
    chk("test kept", 2'b11, tm);
    chk("test width", PULSE_N, wlast);
    chk("test pulses", 3, rises);
    srst_i <= 1'b1;
    cyc(3);
    srst_i <= 1'b0;
    cyc(2);
    chk("por tm", 2'b00, tm);
    chk("por act", 2'b00, act);
    press(30, t);
    chk("normal again", 0, t);
    finish_test();
  end
endmodule
